// ==== pkg/sasr_consts.svh ====
// constants for the serial receiver: register offsets, field positions,
// reset values and bit-timing counts.
// assumes a byte-addressed apb map, one 32-bit word per register.
`ifndef SASR_CONSTS_SVH
`define SASR_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SASR_OFF_CTRL 8'h00
`define SASR_OFF_MATCH 8'h04
`define SASR_OFF_HOLD 8'h08
`define SASR_OFF_STATUS 8'h0c
`define SASR_OFF_CLEAR 8'h10

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define SASR_CTRL_W 7
`define SASR_FLAGS_W 5
`define SASR_CLR_READY_BIT 0
`define SASR_CLR_ERR_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SASR_CTRL_RST 7'h00
`define SASR_HOLD_RST 8'hff
`define SASR_MATCH_RST 8'h00
`define SASR_FLAGS_RST 5'h00

// ----------------------------------------------------------------
// bit timing, in receive clock falls less one
// ----------------------------------------------------------------
`define SASR_DIVM1_1X 6'h00
`define SASR_DIVM1_16X 6'h0f
`define SASR_DIVM1_32X 6'h1f
`define SASR_DIVM1_64X 6'h3f

`endif

// ==== pkg/sasr_pkg.sv ====
// types shared by the serial receiver.
// assumes nothing beyond a systemverilog compiler.
package sasr_pkg;

    // ----------------------------------------------------------------
    // control latch and flag group
    // ----------------------------------------------------------------
    typedef struct packed {
        logic mode_sel_hi;
        logic mode_sel_mid;
        logic mode_sel_lo;
        logic char_len_sel_hi;
        logic char_len_sel_lo;
        logic parity_inhibit;
        logic even_parity_sel;
    } sasr_ctrl_t;

    typedef struct packed {
        logic match_hit;
        logic overrun;
        logic framing_err;
        logic parity_err;
        logic rx_data_ready;
    } sasr_flags_t;

    // ----------------------------------------------------------------
    // receiver states
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        SASR_IDLE = 6'b000001,
        SASR_START = 6'b000010,
        SASR_DATA = 6'b000100,
        SASR_PAR = 6'b001000,
        SASR_STOP = 6'b010000,
        SASR_HUNT = 6'b100000
    } sasr_state_t;

endpackage

// ==== logic/sasr_receiver.sv ====
// serial receiver, sync and async/isoc framing, apb register access.
// assumes rx_clk, serial_in and sync_search are synchronous to pclk and
// rx_clk runs well below pclk so each of its falls is seen.
`timescale 1ns/1ns
`include "sasr_consts.svh"

module sasr_receiver #(
    parameter int ADDR_W = 8
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device control
    input wire logic master_rst,
    input wire logic chip_disable,
    // serial side
    input wire logic rx_clk,
    input wire logic serial_in,
    input wire logic sync_search,
    // bus-side three-state outputs
    output logic [7:0] hold_data,
    output logic hold_oe,
    output sasr_pkg::sasr_flags_t flags,
    output logic flags_oe
);
    import sasr_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    sasr_ctrl_t ctrl_ff;
    sasr_flags_t flags_ff;
    sasr_state_t st_ff;
    sasr_state_t nxt_st;
    logic [7:0] match_ff;
    logic [7:0] hold_ff;
    logic [7:0] sh_ff;
    logic [7:0] nxt_sh;
    logic [5:0] cnt_ff;
    logic [2:0] bits_ff;
    logic par_ff;
    logic rx_clk_ff;
    logic line_ff;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic rx_fall;
    logic sync_mode;
    logic [5:0] div_m1;
    logic [5:0] half_m1;
    logic [2:0] len_m1;
    logic [1:0] len_sel;
    logic bit_due;
    logic half_due;
    logic start_edge;
    logic wr;
    logic wr_ctrl;
    logic wr_match;
    logic clr_ready;
    logic clr_err;
    logic xfer;
    logic hunt_hit;
    logic [7:0] xfer_data;
    logic xfer_par;
    logic xfer_perr;
    logic xfer_ferr;
    logic xfer_match;

    function automatic logic [7:0] align(input logic [7:0] v,
                                         input logic [1:0] ls);
        return v >> (2'd3 - ls);
    endfunction

    function automatic logic [7:0] lenmask(input logic [1:0] ls);
        return 8'hff >> (2'd3 - ls);
    endfunction

    assign len_sel = {ctrl_ff.char_len_sel_hi, ctrl_ff.char_len_sel_lo};
    assign len_m1 = 3'h4 + {1'b0, len_sel};
    assign sync_mode = ctrl_ff.mode_sel_hi;
    assign rx_fall = rx_clk_ff && !rx_clk;

    always_comb begin
        unique case ({ctrl_ff.mode_sel_mid, ctrl_ff.mode_sel_lo})
            2'b00: div_m1 = `SASR_DIVM1_1X;
            2'b01: div_m1 = `SASR_DIVM1_16X;
            2'b10: div_m1 = `SASR_DIVM1_32X;
            2'b11: div_m1 = `SASR_DIVM1_64X;
        endcase
    end
    assign half_m1 = div_m1 >> 1;

    // sync mode takes a bit on every fall; async waits a full bit time
    assign bit_due = rx_fall && (sync_mode || cnt_ff == div_m1);
    assign half_due = rx_fall && cnt_ff == half_m1;
    assign start_edge = rx_fall && line_ff && !serial_in;

    // ----------------------------------------------------------------
    // apb slave: zero wait states, unmapped offsets flag an error
    // ----------------------------------------------------------------
    logic mapped;
    assign mapped = paddr == `SASR_OFF_CTRL || paddr == `SASR_OFF_MATCH
        || paddr == `SASR_OFF_HOLD || paddr == `SASR_OFF_STATUS
        || paddr == `SASR_OFF_CLEAR;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr = psel && penable && pwrite && !chip_disable;
    assign wr_ctrl = wr && paddr == `SASR_OFF_CTRL;
    assign wr_match = wr && paddr == `SASR_OFF_MATCH;
    assign clr_ready = wr && paddr == `SASR_OFF_CLEAR
        && pwdata[`SASR_CLR_READY_BIT];
    assign clr_err = wr && paddr == `SASR_OFF_CLEAR
        && pwdata[`SASR_CLR_ERR_BIT];

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `SASR_OFF_CTRL: prdata[`SASR_CTRL_W-1:0] = ctrl_ff;
            `SASR_OFF_MATCH: prdata[7:0] = match_ff;
            `SASR_OFF_HOLD: prdata[7:0] = hold_ff;
            `SASR_OFF_STATUS: prdata[`SASR_FLAGS_W-1:0] = flags_ff;
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // control and match latches
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `SASR_CTRL_RST;
        end else if (master_rst) begin
            ctrl_ff <= `SASR_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= pwdata[`SASR_CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_ff <= `SASR_MATCH_RST;
        end else if (master_rst) begin
            match_ff <= `SASR_MATCH_RST;
        end else if (wr_match) begin
            match_ff <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // line sampling on receive clock falls
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_clk_ff <= 1'b1;
            line_ff <= 1'b1;
        end else begin
            rx_clk_ff <= rx_clk;
            if (rx_fall) begin
                line_ff <= serial_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // transfer bookkeeping
    // ----------------------------------------------------------------
    // a sync char without parity ends on its last data bit, so the
    // comparison must see the bit being shifted in this cycle
    assign nxt_sh = {serial_in, sh_ff[7:1]};
    assign xfer_data = align((st_ff == SASR_DATA) ? nxt_sh : sh_ff, len_sel)
        & lenmask(len_sel);
    assign xfer_par = (st_ff == SASR_PAR) ? serial_in : par_ff;
    assign xfer_perr = !ctrl_ff.parity_inhibit
        && ((^xfer_data) ^ xfer_par ^ !ctrl_ff.even_parity_sel);
    assign xfer_ferr = !sync_mode && !serial_in;
    assign xfer_match = xfer_data == (match_ff & lenmask(len_sel));
    assign hunt_hit = ctrl_ff.mode_sel_lo
        ? (align(nxt_sh, len_sel) & lenmask(len_sel))
          == (match_ff & lenmask(len_sel))
        : sync_search;

    // ----------------------------------------------------------------
    // framing state machine
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        xfer = 1'b0;
        unique case (st_ff)
            SASR_IDLE: begin
                if (sync_mode) begin
                    nxt_st = SASR_HUNT;
                end else if (start_edge) begin
                    // 1x has no half bit to wait for: no noise check
                    nxt_st = (div_m1 == `SASR_DIVM1_1X)
                        ? SASR_DATA : SASR_START;
                end
            end
            SASR_START: begin
                if (half_due) begin
                    nxt_st = serial_in ? SASR_IDLE : SASR_DATA;
                end
            end
            SASR_DATA: begin
                if (bit_due && bits_ff == len_m1) begin
                    if (!ctrl_ff.parity_inhibit) begin
                        nxt_st = SASR_PAR;
                    end else if (sync_mode) begin
                        xfer = 1'b1;
                    end else begin
                        nxt_st = SASR_STOP;
                    end
                end
            end
            SASR_PAR: begin
                if (bit_due) begin
                    nxt_st = sync_mode ? SASR_DATA : SASR_STOP;
                    xfer = sync_mode;
                end
            end
            SASR_STOP: begin
                if (bit_due) begin
                    nxt_st = SASR_IDLE;
                    xfer = 1'b1;
                end
            end
            SASR_HUNT: begin
                if (rx_fall && hunt_hit) begin
                    nxt_st = SASR_DATA;
                end
            end
            default: nxt_st = SASR_IDLE;
        endcase
        // with the external framer, losing sync_search drops framing and reopens the hunt
        if (sync_mode && !sync_search && !ctrl_ff.mode_sel_lo
            && st_ff != SASR_HUNT) begin
            nxt_st = SASR_HUNT;
            xfer = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= SASR_IDLE;
        end else if (master_rst || wr_ctrl) begin
            st_ff <= SASR_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // bit timer counts from the start edge, restarts at mid start bit and after every bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 6'h00;
        end else if (master_rst || st_ff == SASR_IDLE) begin
            cnt_ff <= 6'h00;
        end else if (st_ff == SASR_START && half_due) begin
            cnt_ff <= 6'h00;
        end else if (bit_due) begin
            cnt_ff <= 6'h00;
        end else if (rx_fall) begin
            cnt_ff <= cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff <= 8'h00;
            bits_ff <= 3'h0;
            par_ff <= 1'b0;
        end else if (master_rst) begin
            sh_ff <= 8'h00;
            bits_ff <= 3'h0;
            par_ff <= 1'b0;
        end else begin
            if ((st_ff == SASR_DATA && bit_due)
                || (st_ff == SASR_HUNT && rx_fall)) begin
                sh_ff <= nxt_sh;
            end
            if (st_ff == SASR_PAR && bit_due) begin
                par_ff <= serial_in;
            end
            if (st_ff == SASR_DATA && bit_due) begin
                bits_ff <= (bits_ff == len_m1) ? 3'h0 : bits_ff + 3'h1;
            end else if (st_ff != SASR_DATA) begin
                bits_ff <= 3'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // holding buffer and flags
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= `SASR_HOLD_RST;
        end else if (master_rst) begin
            hold_ff <= `SASR_HOLD_RST;
        end else if (xfer) begin
            hold_ff <= xfer_data;
        end else if (st_ff == SASR_HUNT && rx_fall) begin
            // transparent while hunting for sync
            hold_ff <= align(nxt_sh, len_sel) & lenmask(len_sel);
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= `SASR_FLAGS_RST;
        end else if (master_rst) begin
            flags_ff <= `SASR_FLAGS_RST;
        end else if (xfer) begin
            flags_ff.rx_data_ready <= 1'b1;
            flags_ff.overrun <= flags_ff.rx_data_ready
                || (flags_ff.overrun && !clr_err);
            flags_ff.parity_err <= xfer_perr
                || (flags_ff.parity_err && !clr_err);
            flags_ff.framing_err <= xfer_ferr;
            flags_ff.match_hit <= xfer_match;
        end else begin
            if (clr_ready) begin
                flags_ff.rx_data_ready <= 1'b0;
            end
            if (clr_err) begin
                flags_ff.parity_err <= 1'b0;
                flags_ff.overrun <= 1'b0;
            end
            if (st_ff == SASR_HUNT && rx_fall && hunt_hit
                && ctrl_ff.mode_sel_lo) begin
                flags_ff.match_hit <= 1'b1;
            end
        end
    end

    assign hold_data = hold_ff;
    assign flags = flags_ff;
    assign hold_oe = !chip_disable;
    assign flags_oe = !chip_disable;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_xfer;
        xfer && !master_rst;
    endsequence

    sequence s_stop_low;
        st_ff == SASR_STOP && bit_due && !serial_in && !master_rst;
    endsequence

    a_xfer_sets_ready: assert property (s_xfer |=> flags_ff.rx_data_ready
        && hold_ff == $past(xfer_data))
        else $error("transfer did not load buffer and ready");
    a_overrun_on_full: assert property (
        s_xfer ##0 flags_ff.rx_data_ready |=> flags_ff.overrun)
        else $error("overrun not raised");
    a_stop_low_frames: assert property (s_stop_low |=> flags_ff.framing_err
        && st_ff == SASR_IDLE)
        else $error("low stop bit not flagged");
    a_noise_start: assert property (st_ff == SASR_START && half_due
        && serial_in && !master_rst |=> st_ff == SASR_IDLE)
        else $error("noise start not rejected");
    a_ready_clear: assert property (clr_ready && !xfer && !master_rst
        |=> !flags_ff.rx_data_ready)
        else $error("ready not cleared");
    a_err_clear: assert property (clr_err && !xfer && !master_rst
        |=> !flags_ff.parity_err && !flags_ff.overrun)
        else $error("error flags not cleared");
    a_reset_idle: assert property (master_rst |=> st_ff == SASR_IDLE
        && hold_ff == 8'hff && flags_ff == 5'h00 && match_ff == 8'h00)
        else $error("master reset did not idle the receiver");
    a_disable_float: assert property (chip_disable |-> !hold_oe
        && !flags_oe)
        else $error("outputs driven while disabled");
    a_disable_nowrite: assert property (chip_disable && !master_rst
        |=> $stable(ctrl_ff) && $stable(match_ff))
        else $error("load accepted while disabled");
    a_shift_on_fall: assert property (st_ff == SASR_DATA && !rx_fall
        && !master_rst |=> $stable(sh_ff))
        else $error("shift without receive clock fall");
endmodule

// ==== verification/sasr_tx_model.sv ====
// far-side model: receive clock source, serial sender, external framer.
// assumes pclk from the bench; rx_clk runs free, four pclk a period.
`timescale 1ns/1ns
module sasr_tx_model (
    // clock from the bench
    input wire logic pclk,
    // serial side
    output logic rx_clk,
    output logic serial_in,
    output logic sync_search
);
    logic [1:0] div_ff = 2'h0;

    initial begin
        rx_clk = 1'b1;
        serial_in = 1'b1;
        sync_search = 1'b0;
    end

    // each level lasts two pclk; the receiver samples every level at two pclk edges
    always @(posedge pclk) begin
        div_ff <= div_ff + 2'h1;
        rx_clk <= ~div_ff[1];
    end

    // ----------------------------------------------------------------
    // line drivers
    // ----------------------------------------------------------------
    // changes only after a rising rx_clk, so every fall sees a settled bit
    task automatic put(input logic b, input int d);
        serial_in <= b;
        repeat (d) @(posedge rx_clk);
    endtask

    // parity bit from the selected length; bad flips it on purpose
    task automatic send(input logic [7:0] d, input int n, input logic par,
        input logic even, input logic bad, input logic stop, input int dv,
        input logic sync);
        logic p;
        p = ^(d & ((8'h01 << n) - 8'h01)) ^ ~even ^ bad;
        @(posedge rx_clk);
        if (sync) begin
            // raised during the bit before the frame
            sync_search <= 1'b1;
            put(1'b1, 1);
        end else begin
            put(1'b0, dv);
        end
        for (int i = 0; i < n; i++) begin
            put(d[i], dv);
        end
        if (par) begin
            put(p, dv);
        end
        if (!sync) begin
            put(stop, dv);
            put(1'b1, 2 * dv);
        end
    endtask

    // a short low pulse that must be rejected as noise
    task automatic glitch(input int k);
        @(posedge rx_clk);
        put(1'b0, k);
        put(1'b1, 40);
    endtask
endmodule

// ==== verification/test_sync_async_serial_receiver.sv ====
// self-checking bench for the serial receiver over apb.
// assumes sasr_receiver, sasr_pkg and the far-side model are compiled.
`timescale 1ns/1ns
`include "sasr_consts.svh"
module test_sync_async_serial_receiver;
    import sasr_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, er, hold_oe, flags_oe;
    logic master_rst = 1'b0;
    logic chip_disable = 1'b0;
    logic rx_clk, serial_in, sync_search;
    logic [7:0] hold_data;
    sasr_flags_t flags;
    logic [7:0] sync_char = 8'ha5;
    int err_total = 0;
    int n_tests = 0;

    always #20 pclk = ~pclk;

    sasr_receiver dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .master_rst(master_rst), .chip_disable(chip_disable),
        .rx_clk(rx_clk), .serial_in(serial_in), .sync_search(sync_search),
        .hold_data(hold_data), .hold_oe(hold_oe), .flags(flags),
        .flags_oe(flags_oe));

    sasr_tx_model tx (.pclk(pclk), .rx_clk(rx_clk), .serial_in(serial_in),
        .sync_search(sync_search));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never completes
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    // holding buffer and flags, by register and at the pins
    task automatic ck_char(input logic [7:0] h, input logic [4:0] s);
        rdc("hold", `SASR_OFF_HOLD, {24'h0, h});
        rdc("status", `SASR_OFF_STATUS, {27'h0, s});
        chk("hold pin", {24'h0, h}, {24'h0, hold_data});
        chk("flag pin", {27'h0, s}, {27'h0, flags});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        ck_char(8'hff, 5'h00);
        rdc("match", `SASR_OFF_MATCH, 32'h0);
        rdc("ctrl", `SASR_OFF_CTRL, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        wr(`SASR_OFF_MATCH, 32'ha5);
        wr(`SASR_OFF_CTRL, 32'h1d);
        tx.send(8'ha5, 8, 1'b1, 1'b1, 1'b0, 1'b1, 16, 1'b0);
        ck_char(8'ha5, 5'h11);
        tx.send(8'h3c, 8, 1'b1, 1'b1, 1'b1, 1'b0, 16, 1'b0);
        ck_char(8'h3c, 5'h0f);
        wr(`SASR_OFF_CLEAR, 32'h1);
        rdc("status", `SASR_OFF_STATUS, 32'h0e);
        tx.send(8'ha5, 8, 1'b1, 1'b1, 1'b0, 1'b1, 16, 1'b0);
        ck_char(8'ha5, 5'h1b);
        wr(`SASR_OFF_CLEAR, 32'h3);
        rdc("status", `SASR_OFF_STATUS, 32'h10);
        // every divisor, each with another length and odd parity
        for (int i = 0; i < 4; i++) begin
            wr(`SASR_OFF_CLEAR, 32'h1);
            wr(`SASR_OFF_CTRL, {25'h0, 1'b0, i[1:0], i[1:0], 2'b00});
            tx.send(8'h5a, 5 + i, 1'b1, 1'b0, 1'b0, 1'b1,
                (i == 0) ? 1 : (16 << (i - 1)), 1'b0);
            ck_char(8'h5a & (8'hff >> (3 - i)), 5'h01);
        end
        wr(`SASR_OFF_CTRL, 32'h1d);
        wr(`SASR_OFF_CLEAR, 32'h1);
        tx.glitch(2);
        rdc("status", `SASR_OFF_STATUS, 32'h0);
        tx.send(8'h81, 8, 1'b1, 1'b1, 1'b0, 1'b1, 16, 1'b0);
        ck_char(8'h81, 5'h01);
        chip_disable <= 1'b1;
        @(posedge pclk);
        chk("hold oe", 32'h0, {31'h0, hold_oe});
        chk("flags oe", 32'h0, {31'h0, flags_oe});
        wr(`SASR_OFF_CTRL, 32'h0);
        wr(`SASR_OFF_CLEAR, 32'h1);
        wr(`SASR_OFF_MATCH, 32'h0);
        chip_disable <= 1'b0;
        rdc("ctrl", `SASR_OFF_CTRL, 32'h1d);
        rdc("status", `SASR_OFF_STATUS, 32'h01);
        rdc("match", `SASR_OFF_MATCH, 32'ha5);
        wr(`SASR_OFF_CTRL, 32'h4e);
        wr(`SASR_OFF_CLEAR, 32'h1);
        tx.send(8'hc3, 8, 1'b0, 1'b0, 1'b0, 1'b1, 1, 1'b1);
        ck_char(8'hc3, 5'h01);
        // internal hunt on the match char, then a framed copy of it
        // with a wrong even-parity bit
        wr(`SASR_OFF_CTRL, 32'h5d);
        wr(`SASR_OFF_CLEAR, 32'h1);
        tx.send(8'ha5, 8, 1'b0, 1'b1, 1'b0, 1'b1, 1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            tx.put(sync_char[i], 1);
        end
        tx.put(1'b1, 1);
        ck_char(8'ha5, 5'h13);
        master_rst <= 1'b1;
        @(posedge pclk);
        master_rst <= 1'b0;
        @(posedge pclk);
        ck_char(8'hff, 5'h00);
        rdc("match", `SASR_OFF_MATCH, 32'h0);
        rdc("ctrl", `SASR_OFF_CTRL, 32'h0);
        results();
    end

    // hang guard, well beyond the longest run of characters
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        results();
    end
endmodule
